// file: agcdb_pkg.sv
// Package with register map, field layouts and timing constants for the AGC debounce block
package agcdb_pkg;
    localparam int unsigned AGCDB_CNT_W         = 17;
    localparam logic [7:0]  AGCDB_OFF_NOISE_DB  = 8'h5b;
    localparam logic [7:0]  AGCDB_OFF_SIGNAL_DB = 8'h5c;
    localparam logic [7:0]  AGCDB_OFF_GAIN      = 8'h5d;
    localparam logic [4:0]  AGCDB_NOISE_RST     = 5'h00;
    localparam logic [3:0]  AGCDB_SIGNAL_RST    = 4'h0;
    localparam int unsigned AGCDB_NOISE_W       = 5;
    localparam int unsigned AGCDB_SIGNAL_W      = 4;
    localparam logic [4:0]  AGCDB_NOISE_POW_MAX = 5'h0a;
    localparam logic [3:0]  AGCDB_SIGNAL_POW_MAX = 4'h9;
    localparam logic [4:0]  AGCDB_THRESH_OFF    = 5'h00;
    localparam logic [AGCDB_CNT_W-1:0] AGCDB_MULT_UNIT = 17'h01000;
    localparam logic [AGCDB_CNT_W-1:0] AGCDB_LEN_ONE   = 17'h00001;
    localparam logic [4:0]  AGCDB_NOISE_SHIFT_OFS  = 5'h01;
    localparam logic [3:0]  AGCDB_SIGNAL_SHIFT_OFS = 4'h1;
    localparam logic signed [7:0] AGCDB_GAIN_MIN = 8'she8;
    localparam logic signed [7:0] AGCDB_GAIN_MAX = 8'sh77;
    localparam logic [7:0]  AGCDB_RD_UNMAPPED   = 8'h00;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } agcdb_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } agcdb_rsp_s;
endpackage : agcdb_pkg

// file: agcdb_top.sv
// AGC noise/signal debounce settings, debounce counters and applied-gain readback
// Functional notes
// - Five-bit noise code: 0 none, up to 10 powers of two, above multiples of 4096.
// - Four-bit signal code: 0 none, 1 gives four periods, each step doubles up to code 9, higher codes hold.
// - Signal code 9 gives 1024 sample periods.
// - Applied gain reads as signed eight-bit value in half-dB steps.
// - Lowest reported gain is -12 dB, code 0xe8.
// - Highest reported gain is 59.5 dB, code 0x77.
// - Gain reading has no reset value and follows the live AGC gain.
// - Debounce durations are counted in ADC sample periods.
// - Noise threshold code zero disables noise detection and its debounce.
`timescale 1ns/10ps

module agcdb_debounce #(
    parameter int unsigned CNT_W = 17
) (
    input  wire logic             clk,     // System clock
    input  wire logic             resetn,  // Async reset, active low
    input  wire logic             enable,  // Detection allowed
    input  wire logic             cond,    // Raw level condition
    input  wire logic             tick,    // One ADC sample period
    input  wire logic [CNT_W-1:0] len,     // Duration in sample periods
    output logic                  det      // Debounced detection
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] cnt_inc;
    logic             det_reg;
    logic             det_next;
    logic             active;
    logic             restart;
    logic             reached;
    logic             advance;

    assign active  = enable && cond;
    assign restart = !active;
    assign reached = (cnt_reg >= len);
    // Only whole sample periods count, and counting stops at the duration
    assign advance = tick && !reached;
    assign cnt_inc = cnt_reg + 1'b1;

    // Any break in the condition restarts the count
    assign cnt_next = restart ? '0 :
                      advance ? cnt_inc : cnt_reg;
    assign det_next = active && reached;
    assign det      = det_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            det_reg <= 1'b0;
        end else begin
            det_reg <= det_next;
        end
    end
endmodule : agcdb_debounce

module agcdb_top (
    input  wire logic              clk,            // 25 MHz system clock
    input  wire logic              resetn,         // Async reset, active low
    input  agcdb_pkg::agcdb_req_s  reg_req,        // Register write/read request
    output agcdb_pkg::agcdb_rsp_s  reg_rsp,        // Read data, valid one cycle
    input  wire logic              sample_tick,    // ADC sample-rate strobe
    input  wire logic [4:0]        noise_thresh,   // Noise threshold code
    input  wire logic              level_is_low,   // Level under noise threshold
    input  wire logic              level_is_high,  // Level above signal threshold
    input  wire logic [7:0]        gain_applied,   // Live AGC gain, half-dB signed
    output logic                   noise_detected, // Debounced noise state
    output logic                   signal_detected // Debounced signal state
);
    import agcdb_pkg::*;

    // Stored settings and response
    logic [AGCDB_NOISE_W-1:0]  noise_code_reg;
    logic [AGCDB_NOISE_W-1:0]  noise_code_next;
    logic [AGCDB_SIGNAL_W-1:0] signal_code_reg;
    logic [AGCDB_SIGNAL_W-1:0] signal_code_next;
    logic signed [7:0]         gain_reg;
    agcdb_rsp_s                rsp_reg;
    agcdb_rsp_s                rsp_next;

    // Address decode
    logic                      sel_noise;
    logic                      sel_signal;
    logic                      sel_gain;
    logic                      wr_noise;
    logic                      wr_signal;

    // Debounce lengths
    logic                      noise_off;
    logic                      noise_is_pow;
    logic [AGCDB_NOISE_W-1:0]  noise_shift;
    logic [AGCDB_CNT_W-1:0]    noise_mult;
    logic [AGCDB_CNT_W-1:0]    noise_pow_len;
    logic [AGCDB_CNT_W-1:0]    noise_mult_len;
    logic [AGCDB_CNT_W-1:0]    noise_len;
    logic                      signal_off;
    logic                      signal_is_pow;
    logic [AGCDB_SIGNAL_W-1:0] signal_shift;
    logic [AGCDB_CNT_W-1:0]    signal_pow_len;
    logic [AGCDB_CNT_W-1:0]    signal_sat_len;
    logic [AGCDB_CNT_W-1:0]    signal_len;
    logic                      noise_en;
    logic                      signal_en;

    // Gain readback
    logic                      gain_under;
    logic                      gain_over;
    logic signed [7:0]         gain_clamped;
    logic [7:0]                noise_rd;
    logic [7:0]                signal_rd;
    logic [7:0]                gain_rd;
    logic [7:0]                rd_mux;

    assign sel_noise  = (reg_req.addr == AGCDB_OFF_NOISE_DB);
    assign sel_signal = (reg_req.addr == AGCDB_OFF_SIGNAL_DB);
    assign sel_gain   = (reg_req.addr == AGCDB_OFF_GAIN);
    assign wr_noise   = reg_req.wr && sel_noise;
    assign wr_signal  = reg_req.wr && sel_signal;

    // Reserved upper bits are never stored, so they read back as zero
    assign noise_code_next  = wr_noise ? reg_req.wdata[AGCDB_NOISE_W-1:0] :
                              noise_code_reg;
    assign signal_code_next = wr_signal ? reg_req.wdata[AGCDB_SIGNAL_W-1:0] :
                              signal_code_reg;

    // Noise code: powers of two 4..2048, then (code-10) x 4096
    assign noise_off      = (noise_code_reg == '0);
    assign noise_is_pow   = (noise_code_reg <= AGCDB_NOISE_POW_MAX);
    assign noise_shift    = noise_code_reg + AGCDB_NOISE_SHIFT_OFS;
    assign noise_pow_len  = AGCDB_LEN_ONE << noise_shift;
    assign noise_mult     = AGCDB_CNT_W'(noise_code_reg - AGCDB_NOISE_POW_MAX);
    assign noise_mult_len = AGCDB_CNT_W'(noise_mult * AGCDB_MULT_UNIT);
    assign noise_len      = noise_off    ? '0 :
                            noise_is_pow ? noise_pow_len : noise_mult_len;

    // Signal code: doubling from 4, codes past 9 hold at 1024
    assign signal_off     = (signal_code_reg == '0);
    assign signal_is_pow  = (signal_code_reg <= AGCDB_SIGNAL_POW_MAX);
    assign signal_shift   = signal_code_reg + AGCDB_SIGNAL_SHIFT_OFS;
    assign signal_pow_len = AGCDB_LEN_ONE << signal_shift;
    assign signal_sat_len = AGCDB_LEN_ONE << (AGCDB_SIGNAL_POW_MAX + AGCDB_SIGNAL_SHIFT_OFS);
    assign signal_len     = signal_off    ? '0 :
                            signal_is_pow ? signal_pow_len : signal_sat_len;

    // A zero threshold code switches noise detection off entirely
    assign noise_en  = (noise_thresh != AGCDB_THRESH_OFF);
    // Signal detection has no off switch of its own
    assign signal_en = 1'b1;

    // Reported gain held inside the documented range
    assign gain_under   = (gain_reg < AGCDB_GAIN_MIN);
    assign gain_over    = (gain_reg > AGCDB_GAIN_MAX);
    assign gain_clamped = gain_under ? AGCDB_GAIN_MIN :
                          gain_over  ? AGCDB_GAIN_MAX :
                          gain_reg;

    // Codes are zero-extended, the gain keeps its sign bit
    assign noise_rd  = 8'(noise_code_reg);
    assign signal_rd = 8'(signal_code_reg);
    assign gain_rd   = gain_clamped;
    assign rd_mux    = sel_noise  ? noise_rd :
                       sel_signal ? signal_rd :
                       sel_gain   ? gain_rd :
                       AGCDB_RD_UNMAPPED;

    // Response pulses for one cycle, data holds until the next read
    assign rsp_next.valid = reg_req.rd;
    assign rsp_next.data  = reg_req.rd ? rd_mux : rsp_reg.data;
    assign reg_rsp        = rsp_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            noise_code_reg  <= AGCDB_NOISE_RST;
            signal_code_reg <= AGCDB_SIGNAL_RST;
        end else begin
            noise_code_reg  <= noise_code_next;
            signal_code_reg <= signal_code_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    // Live gain sample, deliberately without reset
    always_ff @(posedge clk) begin
        gain_reg <= gain_applied;
    end

    agcdb_debounce #(
        .CNT_W (AGCDB_CNT_W)
    ) u_noise_db (
        .clk    (clk),
        .resetn (resetn),
        .enable (noise_en),
        .cond   (level_is_low),
        .tick   (sample_tick),
        .len    (noise_len),
        .det    (noise_detected)
    );

    agcdb_debounce #(
        .CNT_W (AGCDB_CNT_W)
    ) u_signal_db (
        .clk    (clk),
        .resetn (resetn),
        .enable (signal_en),
        .cond   (level_is_high),
        .tick   (sample_tick),
        .len    (signal_len),
        .det    (signal_detected)
    );
endmodule : agcdb_top

// file: agcdb_chk.sv
// Checker for the AGC debounce block ports
`timescale 1ns/10ps
module agcdb_chk import agcdb_pkg::*; (
    input wire logic             clk,             // Clock
    input wire logic             resetn,          // Reset
    input agcdb_pkg::agcdb_req_s reg_req,         // Request
    input agcdb_pkg::agcdb_rsp_s reg_rsp,         // Response
    input wire logic             sample_tick,     // Tick
    input wire logic [4:0]       noise_thresh,    // Threshold
    input wire logic             level_is_low,    // Low
    input wire logic             level_is_high,   // High
    input wire logic [7:0]       gain_applied,    // Gain
    input wire logic             noise_detected,  // Noise
    input wire logic             signal_detected  // Signal
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire rd_g = reg_req.rd && reg_req.addr == AGCDB_OFF_GAIN;
    AST_RD_VALID: assert property (reg_req.rd |=> reg_rsp.valid) else $error("no valid");
    AST_NO_RD: assert property (!reg_req.rd |=> !reg_rsp.valid) else $error("spur");
    AST_GAIN_RANGE: assert property (rd_g |=> $signed(reg_rsp.data) >= AGCDB_GAIN_MIN &&
        $signed(reg_rsp.data) <= AGCDB_GAIN_MAX) else $error("gain range");
    AST_NOISE_UPPER: assert property (reg_req.rd && reg_req.addr == AGCDB_OFF_NOISE_DB
        |=> reg_rsp.data[7:5] == 3'h0) else $error("noise bits");
    AST_SIG_UPPER: assert property (reg_req.rd && reg_req.addr == AGCDB_OFF_SIGNAL_DB
        |=> reg_rsp.data[7:4] == 4'h0) else $error("signal bits");
    AST_NOISE_OFF: assert property (noise_thresh == AGCDB_THRESH_OFF |=> !noise_detected)
        else $error("noise off");
    AST_SIG_DROP: assert property (!level_is_high |=> !signal_detected) else $error("sig");
    AST_NOISE_DROP: assert property (!level_is_low |=> !noise_detected) else $error("nse");
    cover property ($rose(signal_detected));
    cover property ($rose(noise_detected));
    cover property (rd_g ##1 reg_rsp.valid);
endmodule : agcdb_chk

bind agcdb_top agcdb_chk i_chk (.clk(clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .sample_tick(sample_tick), .noise_thresh(noise_thresh),
    .level_is_low(level_is_low), .level_is_high(level_is_high), .gain_applied(gain_applied),
    .noise_detected(noise_detected), .signal_detected(signal_detected));

// file: agcdb_top_tb_top.sv
// Self-checking testbench for the AGC debounce block
`timescale 1ns/10ps
module agcdb_top_tb_top;
    import agcdb_pkg::*;
    logic       clk = 1'b0, resetn = 1'b0, sample_tick = 1'b1, level_is_low = 1'b0;
    logic       level_is_high = 1'b0, noise_detected, signal_detected;
    logic [4:0] noise_thresh = 5'h01;
    logic [7:0] gain_applied = 8'h00, q[$];
    agcdb_req_s reg_req = '0;
    agcdb_rsp_s reg_rsp;
    int         mismatches = 0, cmp_count = 0, k;
    logic [15:0] gt[$] = '{16'he8e8, 16'h7777, 16'h0000, 16'he7e8, 16'h80e8, 16'h7f77};
    int          nc[5] = '{0, 1, 10, 11, 12};
    always #20 clk = ~clk;
    // Sample-rate strobe on every second clock
    always @(negedge clk) sample_tick = ~sample_tick;
    agcdb_top i_dut (.clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .sample_tick(sample_tick), .noise_thresh(noise_thresh), .level_is_low(level_is_low),
        .level_is_high(level_is_high), .gain_applied(gain_applied),
        .noise_detected(noise_detected), .signal_detected(signal_detected));
    task automatic results;
        if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        cmp_count++;
        if (a !== e) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask : chk
    // Read when w is low: d is the expected data, checked by the monitor
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
        if (!w) q.push_back(d);
        @(negedge clk);
        reg_req = '0;
    endtask : acc
    always @(negedge clk) if (reg_rsp.valid === 1'b1) chk(reg_rsp.data, q.pop_front());
    // Short excursion first, then time the full debounce from the second rise
    task automatic meas(input logic s, input int n);
        {level_is_high, level_is_low} = {s, !s};
        repeat (n / 2 + 1) @(negedge clk);
        {level_is_high, level_is_low} = 2'b00;
        repeat (2) @(negedge clk);
        {level_is_high, level_is_low} = {s, !s};
        for (k = 1; k <= 2 * n + 4; k++) begin
            @(negedge clk);
            if ((s ? signal_detected : noise_detected) === 1'b1) break;
        end
        chk(8'(k >= 2 * n && k <= 2 * n + 1), 8'h01);
        if (k > 2 * n + 4) results();
        {level_is_high, level_is_low} = 2'b00;
        @(negedge clk);
    endtask : meas
    initial begin
        void'($urandom(22));
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        acc(0, AGCDB_OFF_NOISE_DB, 8'h00);
        acc(0, AGCDB_OFF_SIGNAL_DB, 8'h00);
        acc(1, AGCDB_OFF_GAIN, 8'h55);
        acc(0, 8'h5e, AGCDB_RD_UNMAPPED);
        acc(1, AGCDB_OFF_NOISE_DB, 8'h1f);
        acc(0, AGCDB_OFF_NOISE_DB, 8'h1f);
        acc(1, AGCDB_OFF_SIGNAL_DB, 8'h0f);
        acc(0, AGCDB_OFF_SIGNAL_DB, 8'h0f);
        @(negedge clk);
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        acc(0, AGCDB_OFF_NOISE_DB, 8'h00);
        acc(0, AGCDB_OFF_SIGNAL_DB, 8'h00);
        for (int c = 0; c <= 10; c++) begin
            acc(1, AGCDB_OFF_SIGNAL_DB, 8'(c));
            meas(1, c == 0 ? 0 : 2 << (c > 9 ? 9 : c));
        end
        noise_thresh = 5'($urandom_range(1, 31));
        foreach (nc[i]) begin
            acc(1, AGCDB_OFF_NOISE_DB, 8'(nc[i]));
            meas(0, nc[i] == 0 ? 0 : nc[i] <= 10 ? 2 << nc[i] : (nc[i] - 10) * 4096);
        end
        noise_thresh = AGCDB_THRESH_OFF;
        acc(1, AGCDB_OFF_NOISE_DB, 8'h00);
        level_is_low = 1'b1;
        repeat (8) @(negedge clk);
        chk({7'h0, noise_detected}, 8'h00);
        level_is_low = 1'b0;
        repeat (4) gt.push_back({2{8'($urandom_range(0, 143)) - 8'd24}});
        foreach (gt[i]) begin
            gain_applied = gt[i][15:8];
            repeat (2) @(negedge clk);
            acc(0, AGCDB_OFF_GAIN, gt[i][7:0]);
        end
        repeat (3) @(negedge clk);
        chk(8'(q.size()), 8'h00);
        results();
    end
endmodule : agcdb_top_tb_top
